//--- inc/phyc_pkg.sv
// Package of register map, field layouts and timing for the PHY config bank.
`default_nettype none
package phyc_pkg;
   // ****************************************
   // Register indices (byte address = 4 * index).
   // ****************************************
   localparam int         ADDR_W    = 10;
   localparam logic [7:0] IDX_RGMII = 8'h33;
   localparam logic [7:0] IDX_FE    = 8'h43;
   localparam logic [7:0] IDX_VIT   = 8'h53;
   localparam logic [7:0] IDX_SKEW  = 8'h55;
   localparam logic [7:0] IDX_STRAP = 8'h6e;

   // ****************************************
   // Field layouts and reset values.
   // ****************************************
   typedef struct packed {
      logic [3:0] rsvd;
      logic       unscramble_timeout_off;
      logic [3:0] unscramble_recovery_ms;
      logic       force_good_link;
      logic       enhanced_three_level_detect;
      logic       enhanced_gap_detect;
      logic       rx_block_decoder_bypass;
      logic       scrambler_off;
      logic       odd_nibble_detect;
      logic       early_receive_valid;
   } phyc_fe_cfg_t;

   localparam phyc_fe_cfg_t FE_RST = 16'h07a0;
   localparam logic [3:0]   VIT_RST = 4'h5;
   localparam logic [11:0]  VIT_RSVD = 12'h205;

   typedef struct packed {
      logic [3:0] chan_b_align_skew;
      logic [3:0] chan_a_align_skew;
   } phyc_skew_t;

   // Strap pin levels as sampled from the board.
   typedef struct packed {
      logic       mirror;
      logic       downshift;
      logic       strapped_clock_output_off;
      logic       strapped_mac_port_off;
      logic       strapped_auto_crossover_off;
      logic       strapped_forced_crossover;
      logic       strapped_half_duplex;
      logic       strapped_autoneg_off;
      logic [1:0] strapped_speed_pair;
      logic [4:0] strapped_station_address;
   } phyc_strap_pins_t;

   // Strap status register image.
   typedef struct packed {
      logic       mirror;
      logic       downshift;
      logic       clk_out_off;
      logic       mac_port_off;
      logic       rsvd;
      logic       auto_xover_off;
      logic       forced_xover;
      logic       half_duplex;
      logic       autoneg_off;
      logic [1:0] speed;
      logic [4:0] station;
   } phyc_strap_sts_t;

   // ****************************************
   // Timing.
   // ****************************************
   localparam real CLK_MHZ            = 250.0;
   localparam real DESCR_TIMEOUT_MS   = 1.5;
   localparam int  DESCR_TIMEOUT_CYC  = int'(DESCR_TIMEOUT_MS * 1000.0 * CLK_MHZ);
   localparam int  CNT_W              = 24;
endpackage
`default_nettype wire

//--- hdl/phyc_regs.sv
// PHY configuration and strap status register bank behind an APB slave.
`default_nettype none
module phyc_regs #(
   parameter int unsigned TIMEOUT_CYC   = phyc_pkg::DESCR_TIMEOUT_CYC,
   parameter bit          LARGE_PACKAGE = 1'b1
) (
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [phyc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire phyc_pkg::phyc_strap_pins_t strap_pins,
   input  wire phyc_pkg::phyc_skew_t      rx_skew,
   input  wire logic                      rx_frame_active,
   input  wire logic                      link_qualified,
   output logic                           async_fifo_bypass_en,
   output phyc_pkg::phyc_fe_cfg_t         fe_cfg,
   output logic      [3:0]                viterbi_idle_threshold,
   output logic                           link_good,
   output logic                           rx_timeout_abort,
   output phyc_pkg::phyc_strap_sts_t      strap_status
);

   // ****************************************
   // State.
   // ****************************************
   typedef struct packed {
      logic                      bypass;
      phyc_pkg::phyc_fe_cfg_t    fe;
      logic [3:0]                vit;
      phyc_pkg::phyc_strap_sts_t straps;
      logic                      strap_taken;
      logic [phyc_pkg::CNT_W-1:0] frame_cnt;
      logic                      abort;
      logic                      link_good;
      logic                      pready;
      logic                      pslverr;
      logic [31:0]               prdata;
   } phyc_state_t;

   phyc_state_t st;
   phyc_state_t next_st;

   localparam logic [phyc_pkg::CNT_W-1:0] TIMEOUT_LIM =
      phyc_pkg::CNT_W'(TIMEOUT_CYC);

   logic [7:0]  idx;
   logic        access;
   logic        commit;
   logic        mapped;
   logic [15:0] rd_word;
   phyc_pkg::phyc_strap_sts_t strap_img;

   assign idx    = paddr[9:2];
   assign access = psel && penable;
   assign commit = access && st.pready;

   // ****************************************
   // Address decode and read mux.
   // ****************************************
   always_comb begin
      mapped  = 1'b1;
      rd_word = 16'h0000;
      case (idx)
         phyc_pkg::IDX_RGMII: begin
            rd_word = {11'h000, st.bypass, 4'h0};
         end
         phyc_pkg::IDX_FE: begin
            rd_word = {4'h0, st.fe[11:0]};
         end
         phyc_pkg::IDX_VIT: begin
            rd_word = {phyc_pkg::VIT_RSVD, st.vit};
         end
         phyc_pkg::IDX_SKEW: begin
            rd_word = {8'h00, rx_skew};
         end
         phyc_pkg::IDX_STRAP: begin
            rd_word = st.straps;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Strap image per package variant.
   // ****************************************
   always_comb begin
      strap_img                = '0;
      strap_img.mirror         = strap_pins.mirror;
      strap_img.downshift      = strap_pins.downshift;
      strap_img.mac_port_off   = strap_pins.strapped_mac_port_off;
      strap_img.auto_xover_off = strap_pins.strapped_auto_crossover_off;
      strap_img.forced_xover   = strap_pins.strapped_forced_crossover;
      strap_img.half_duplex    = strap_pins.strapped_half_duplex;
      strap_img.autoneg_off    = strap_pins.strapped_autoneg_off;
      if (LARGE_PACKAGE) begin
         strap_img.clk_out_off = strap_pins.strapped_clock_output_off;
         strap_img.speed       = strap_pins.strapped_speed_pair;
         strap_img.station     = strap_pins.strapped_station_address;
      end else begin
         // The small package has one speed pin and four address pins.
         strap_img.speed   = {1'b0, strap_pins.strapped_speed_pair[0]};
         strap_img.station = {1'b0, strap_pins.strapped_station_address[3:0]};
      end
   end

   // ****************************************
   // Next state.
   // ****************************************
   always_comb begin
      next_st = st;

      // Straps are sampled once, on the first cycle out of reset.
      if (!st.strap_taken) begin
         next_st.straps      = strap_img;
         next_st.strap_taken = 1'b1;
      end

      // One wait state: pready rises in the second access cycle.
      next_st.pready  = access && !st.pready;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
      if (access && !st.pready) begin
         next_st.pslverr = !mapped;
         if (!pwrite) begin
            next_st.prdata = {16'h0000, rd_word};
         end
      end

      // Writes take effect only at the completing edge.
      if (commit && pwrite) begin
         case (idx)
            phyc_pkg::IDX_RGMII: begin
               next_st.bypass = pwdata[4];
            end
            phyc_pkg::IDX_FE: begin
               next_st.fe.unscramble_timeout_off =
                  pwdata[11];
               next_st.fe.unscramble_recovery_ms =
                  pwdata[10:7];
               next_st.fe.force_good_link = pwdata[6];
               next_st.fe.enhanced_three_level_detect =
                  pwdata[5];
               next_st.fe.enhanced_gap_detect = pwdata[4];
               next_st.fe.rx_block_decoder_bypass =
                  pwdata[3];
               next_st.fe.scrambler_off = pwdata[2];
               next_st.fe.odd_nibble_detect = pwdata[1];
               next_st.fe.early_receive_valid =
                  pwdata[0];
            end
            phyc_pkg::IDX_VIT: begin
               next_st.vit = pwdata[3:0];
            end
            default: begin
               // Read-only and unmapped words ignore writes.
               next_st.vit = st.vit;
            end
         endcase
      end

      // Frame length watchdog; the abort holds until the frame ends or unscramble_timeout_off is set.
      if (!rx_frame_active) begin
         next_st.frame_cnt = '0;
         next_st.abort     = 1'b0;
      end else begin
         if (st.frame_cnt < TIMEOUT_LIM) begin
            next_st.frame_cnt = st.frame_cnt + 1'b1;
         end
         next_st.abort = (st.abort || (st.frame_cnt >= TIMEOUT_LIM))
                         && !st.fe.unscramble_timeout_off;
      end

      next_st.link_good = st.fe.force_good_link || link_qualified;
   end

   // ****************************************
   // Registers.
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st        <= '0;
         st.fe     <= phyc_pkg::FE_RST;
         st.vit    <= phyc_pkg::VIT_RST;
      end else begin
         st <= next_st;
      end
   end

   assign prdata                 = st.prdata;
   assign pready                 = st.pready;
   assign pslverr                = st.pslverr;
   assign async_fifo_bypass_en   = st.bypass;
   assign fe_cfg                 = st.fe;
   assign viterbi_idle_threshold = st.vit;
   assign link_good              = st.link_good;
   assign rx_timeout_abort       = st.abort;
   assign strap_status           = st.straps;

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   logic wr_fe;
   logic wr_vit;
   logic wr_ro;
   logic rd_sel_rgmii;
   logic rd_sel_skew;
   logic rd_sel_strap;
   assign wr_fe        = commit && pwrite && (idx == phyc_pkg::IDX_FE);
   assign wr_vit       = commit && pwrite && (idx == phyc_pkg::IDX_VIT);
   // Read-only words swallow writes silently; software gets no error for them.
   assign wr_ro        = commit && pwrite
                         && (idx == phyc_pkg::IDX_SKEW || idx == phyc_pkg::IDX_STRAP);
   assign rd_sel_rgmii = access && !st.pready && !pwrite
                         && (idx == phyc_pkg::IDX_RGMII);
   assign rd_sel_skew  = access && !st.pready && !pwrite
                         && (idx == phyc_pkg::IDX_SKEW);
   assign rd_sel_strap = access && !st.pready && !pwrite
                         && (idx == phyc_pkg::IDX_STRAP);

   chk_bypass_write: assert property (
      (commit && pwrite && idx == phyc_pkg::IDX_RGMII)
      |=> (async_fifo_bypass_en == $past(pwdata[4])))
      else $error("FIFO bypass bit did not follow write.");

   chk_abort_cause: assert property (
      $rose(rx_timeout_abort)
      |-> ($past(rx_frame_active) && !$past(fe_cfg.unscramble_timeout_off)
           && $past(st.frame_cnt) >= TIMEOUT_LIM))
      else $error("Abort without an expired frame timer.");

   chk_abort_off: assert property (
      fe_cfg.unscramble_timeout_off |=> !rx_timeout_abort)
      else $error("Abort raised while timeout is disabled.");

   chk_fe_defaults: assert property (
      $past(srst) |-> (fe_cfg.unscramble_recovery_ms == 4'hf
                      && fe_cfg.enhanced_three_level_detect
                      && !fe_cfg.enhanced_gap_detect))
      else $error("Fast Ethernet config reset value wrong.");

   chk_force_link: assert property (
      fe_cfg.force_good_link |=> link_good)
      else $error("Forced link not reported good.");

   chk_fe_write: assert property (
      wr_fe |=> (fe_cfg[11:0] == $past(pwdata[11:0])))
      else $error("Fast Ethernet config did not take write.");

   chk_vit_reset: assert property (
      $past(srst) |-> (viterbi_idle_threshold == 4'h5))
      else $error("Viterbi threshold reset value wrong.");

   chk_skew_read: assert property (
      rd_sel_skew |=> (pready && prdata == {24'h000000, $past(rx_skew)}))
      else $error("Skew register read mismatch.");

   chk_strap_read: assert property (
      rd_sel_strap |=> (prdata[15:0] == strap_status))
      else $error("Strap register read mismatch.");

   chk_strap_hold: assert property (
      (st.strap_taken && $past(st.strap_taken)) |-> $stable(strap_status))
      else $error("Strap status changed after capture.");

   chk_small_zero: assert property (
      !LARGE_PACKAGE |-> (!strap_status.speed[1] && !strap_status.station[4]
                          && !strap_status.clk_out_off))
      else $error("Small variant reserved strap bits set.");

   chk_bypass_read: assert property (
      rd_sel_rgmii
      |=> (prdata == {27'h0000000, async_fifo_bypass_en, 4'h0}))
      else $error("FIFO bypass register read mismatch.");

   chk_vit_write: assert property (
      wr_vit |=> (viterbi_idle_threshold == $past(pwdata[3:0])))
      else $error("Viterbi threshold did not take write.");

   chk_ro_ignore: assert property (
      wr_ro |=> ($stable(strap_status) && $stable(fe_cfg)
                 && $stable(viterbi_idle_threshold) && $stable(async_fifo_bypass_en)))
      else $error("Write to a read-only register changed state.");

   chk_strap_capture: assert property (
      !st.strap_taken |=> (strap_status == $past(strap_img)))
      else $error("Strap image not captured after reset.");

   chk_unmapped_err: assert property (
      (access && !st.pready && !mapped) |=> (pready && pslverr && prdata == 32'h0000_0000))
      else $error("Unmapped access did not answer with an error.");

   chk_link_normal: assert property (
      (!fe_cfg.force_good_link && !link_qualified) |=> !link_good)
      else $error("Link reported good without cause.");

   chk_abort_clear: assert property (
      !rx_frame_active |=> !rx_timeout_abort)
      else $error("Abort held after the frame ended.");

   chk_fe_reserved: assert property (
      fe_cfg.rsvd == 4'h0)
      else $error("Reserved configuration bits set.");

   cov_fe_write: cover property (wr_fe);
   cov_abort: cover property ($rose(rx_timeout_abort));
   cov_strap_read: cover property (rd_sel_strap ##1 pready);
   cov_unmapped: cover property (pslverr);
   cov_forced_link: cover property (fe_cfg.force_good_link && !link_qualified ##1 link_good);

endmodule
`default_nettype wire

//--- test/phyc_tb.sv
// Self-checking testbench for the PHY configuration and strap status register bank.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Stimulus nets and design instances.
   // ****************************************
   localparam int         TCYC = 20;
   localparam logic [9:0] A_RG = 10'h0cc, A_FE = 10'h10c, A_VT = 10'h14c;
   localparam logic [9:0] A_SK = 10'h154, A_ST = 10'h1b8;
   localparam phyc_pkg::phyc_strap_pins_t S0 = 15'h2cd6;
   logic                       core_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic                       rx_frame_active, link_qualified, bypass, link_good, abort, er;
   logic [9:0]                 paddr;
   logic [31:0]                pwdata, prdata, rd;
   logic [3:0]                 vit_thr;
   phyc_pkg::phyc_strap_pins_t strap_pins;
   phyc_pkg::phyc_skew_t       rx_skew;
   phyc_pkg::phyc_fe_cfg_t     fe_cfg;
   phyc_pkg::phyc_strap_sts_t  strap_sts, strap_sts_s;
   int                         err_total, n_tests, cycles;

   phyc_regs #(.TIMEOUT_CYC(TCYC), .LARGE_PACKAGE(1'b1)) dut_u (
      .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_pins(strap_pins), .rx_skew(rx_skew), .rx_frame_active(rx_frame_active),
      .link_qualified(link_qualified), .async_fifo_bypass_en(bypass), .fe_cfg(fe_cfg),
      .viterbi_idle_threshold(vit_thr), .link_good(link_good), .rx_timeout_abort(abort),
      .strap_status(strap_sts));
   // The small variant shares the bus; only its strap image is compared.
   phyc_regs #(.TIMEOUT_CYC(TCYC), .LARGE_PACKAGE(1'b0)) dut_s (
      .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .strap_pins(strap_pins), .rx_skew(rx_skew), .rx_frame_active(rx_frame_active),
      .link_qualified(link_qualified), .async_fifo_bypass_en(), .fe_cfg(),
      .viterbi_idle_threshold(), .link_good(), .rx_timeout_abort(), .strap_status(strap_sts_s));

   // ****************************************
   // Helpers.
   // ****************************************
   function automatic logic [15:0] strap_img(phyc_pkg::phyc_strap_pins_t p, bit big);
      logic [15:0] v;
      v = {p.mirror, p.downshift, p.strapped_clock_output_off, p.strapped_mac_port_off, 1'b0,
           p.strapped_auto_crossover_off, p.strapped_forced_crossover, p.strapped_half_duplex,
           p.strapped_autoneg_off, p.strapped_speed_pair, p.strapped_station_address};
      if (!big) begin
         v = v & 16'hdfaf;
      end
      return v;
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // Entered just after a rising edge; pready is sampled at the rising edge that ends the access,
   // before that edge's updates land, and an idle cycle follows every transfer.
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rdchk(input logic [9:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
      chk("slave error", 32'h0, {31'h0, er});
   endtask

   task automatic ticks(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // ****************************************
   // Clock, timeout and test sequence.
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      {psel, penable, pwrite, rx_frame_active, link_qualified} = 5'h00;
      {err_total, n_tests, cycles} = {32'd0, 32'd0, 32'd0};
      {paddr, pwdata, rx_skew} = {10'h000, 32'h0000_0000, 8'h00};
      srst = 1'b1;
      strap_pins = S0;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      repeat (3) @(posedge core_clk);
      // Pins move after capture; the latched image must not follow them.
      strap_pins <= ~S0;
      rx_skew    <= 8'h9c;
      @(posedge core_clk);
      rdchk(A_RG, 32'h0000_0000, "fifo bypass reg");
      rdchk(A_FE, 32'h0000_07a0, "fast eth reg");
      rdchk(A_VT, 32'h0000_2055, "viterbi reg");
      rdchk(A_SK, 32'h0000_009c, "skew reg");
      rdchk(A_ST, {16'h0, strap_img(S0, 1'b1)}, "strap reg");
      chk("small strap", {16'h0, strap_img(S0, 1'b0)}, {16'h0, strap_sts_s});
      chk("strap port", {16'h0, strap_img(S0, 1'b1)}, {16'h0, strap_sts});
      chk("link good idle", 32'h0, {31'h0, link_good});
      apb(1'b1, A_RG, 32'hffff_ffff);
      rdchk(A_RG, 32'h0000_0010, "fifo bypass set");
      chk("bypass port", 32'h1, {31'h0, bypass});
      apb(1'b1, A_RG, 32'h0000_0000);
      chk("bypass clear", 32'h0, {31'h0, bypass});
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, A_FE, 32'h1 << i);
         rdchk(A_FE, (i < 12) ? 32'h1 << i : 32'h0, "fast eth bit");
         chk("fe port", (i < 12) ? 32'h1 << i : 32'h0, {16'h0, fe_cfg});
         chk("forced link", {31'h0, i == 6}, {31'h0, link_good});
      end
      apb(1'b1, A_FE, 32'h0000_07a0);
      apb(1'b1, A_VT, 32'hffff_fff4);
      rdchk(A_VT, 32'h0000_2054, "viterbi write");
      chk("viterbi port", 32'h4, {28'h0, vit_thr});
      apb(1'b1, A_SK, 32'hffff_ffff);
      apb(1'b1, A_ST, 32'hffff_ffff);
      rdchk(A_SK, 32'h0000_009c, "skew ro");
      rdchk(A_ST, {16'h0, strap_img(S0, 1'b1)}, "strap ro");
      apb(1'b0, 10'h3fc, 32'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped error", 32'h1, {31'h0, er});
      link_qualified <= 1'b1;
      ticks(2);
      chk("qualified link", 32'h1, {31'h0, link_good});
      @(posedge core_clk);
      link_qualified  <= 1'b0;
      rx_frame_active <= 1'b1;
      ticks(TCYC - 2);
      chk("abort early", 32'h0, {31'h0, abort});
      ticks(6);
      chk("abort late", 32'h1, {31'h0, abort});
      @(posedge core_clk);
      rx_frame_active <= 1'b0;
      ticks(2);
      chk("abort end", 32'h0, {31'h0, abort});
      @(posedge core_clk);
      apb(1'b1, A_FE, 32'h0000_0fa0);
      rx_frame_active <= 1'b1;
      ticks(TCYC + 8);
      chk("abort disabled", 32'h0, {31'h0, abort});
      @(posedge core_clk);
      rx_frame_active <= 1'b0;
      srst            <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rdchk(A_FE, 32'h0000_07a0, "fe rereset");
      rdchk(A_ST, {16'h0, strap_img(~S0, 1'b1)}, "strap recapture");
      rdchk(A_VT, 32'h0000_2055, "viterbi rereset");
      chk("small recapture", {16'h0, strap_img(~S0, 1'b0)}, {16'h0, strap_sts_s});
      complete_run();
   end
endmodule
`default_nettype wire
